// [verilog/afm_top.sv]
`include "afm_params.svh"

// ****************************************
// Frame timing monitor with AXI4-Lite registers.
// ****************************************
module afm_top
  import afm_pkg::*;
#(
  // Receive buffers and how many the engine serves at once.
  parameter int RX_REQ_N = 4,
  parameter int RX_SERVE = 1,
  // Transmit buffers and how many the engine fetches at once.
  parameter int TX_REQ_N = 4,
  parameter int TX_SERVE = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // AXI4-Lite write address.
  input wire logic [`AFM_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address.
  input wire logic [`AFM_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial link pins from the host.
  input wire logic sclk,
  input wire logic word_select,
  // Receive and transmit engine requests.
  input wire logic rx_core_tick,
  input wire logic [RX_REQ_N-1:0] rx_buf_req,
  input wire logic [TX_REQ_N-1:0] tx_buf_req,
  // Interrupt.
  output logic irq
);
  // ****************************************
  // Elaboration checks.
  // ****************************************
  // One served request at least, and fewer than there are buffers.
  if (RX_SERVE < 1 || RX_SERVE >= RX_REQ_N) begin : g_bad_rx
    $error("RX_SERVE must lie in 1 .. RX_REQ_N-1.");
  end
  if (TX_SERVE < 1 || TX_SERVE >= TX_REQ_N) begin : g_bad_tx
    $error("TX_SERVE must lie in 1 .. TX_REQ_N-1.");
  end

  // ****************************************
  // Declarations.
  // ****************************************
  // Byte addresses of the status registers.
  localparam logic [`AFM_AW-1:0] RX_STAT_A =
    `AFM_AW'(`AFM_RX_STAT_IDX * 4);
  localparam logic [`AFM_AW-1:0] TX_STAT_A =
    `AFM_AW'(`AFM_TX_STAT_IDX * 4);

  afm_top_t s_ff; // Whole state.
  afm_top_t nxt_s; // Next whole state.
  logic [1:0] link_q; // Synchronised bit clock and word select.
  logic sclk_rise; // Bit clock rose.
  logic ws_rise; // Word select rose.
  logic ws_fall; // Word select fell.
  logic core_slow; // Ninth bit-clock rise in one core period.
  logic rx_over; // Too many receive requests at once.
  logic tx_over; // Too many transmit fetches at once.
  afm_rx_stat_t rx_stat; // Receive status byte.
  afm_tx_stat_t tx_stat; // Transmit status byte.
  logic [11:0] cur_flags; // Status flags in pending layout.
  logic [11:0] rises; // Flags that rose this cycle.
  logic [11:0] clr; // Pending bits cleared by software.
  logic [31:0] wmask; // Byte-lane mask from the strobes.
  logic [`AFM_AW-1:0] waddr; // Aligned write address.
  logic [`AFM_AW-1:0] raddr; // Aligned read address.
  logic wr_go; // A write is taken now.
  logic rd_go; // A read is taken now.

  // Result bundles of the two checkers.
  afm_flag_if rx_flags ();
  afm_flag_if tx_flags ();

  // Merges written byte lanes into an old register value.
  function automatic logic [31:0] afm_merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [31:0] m
  );
    return (old & ~m) | (wd & m);
  endfunction : afm_merge

  // ****************************************
  // Link front end.
  // ****************************************
  // Both pins come from the host's domain and are synchronised.
  afm_sync u_sync (
    .clk (clk),
    .reset_n (reset_n),
    .pin_in ({word_select, sclk}),
    .pin_sync (link_q)
  );

  // Edges are found against the last synchronised value.
  assign sclk_rise = link_q[0] & ~s_ff.sclk_d;
  assign ws_rise = link_q[1] & ~s_ff.ws_d;
  assign ws_fall = ~link_q[1] & s_ff.ws_d;

  // Receive checker, driven by the receive settings.
  afm_phase_check u_rx_chk (
    .clk (clk),
    .reset_n (reset_n),
    .sclk_rise (sclk_rise),
    .ws_rise (ws_rise),
    .ws_fall (ws_fall),
    .balanced (s_ff.ctrl[`AFM_BAL_RX]),
    .period (s_ff.rx_cfg[`AFM_PER]),
    .width (s_ff.rx_cfg[`AFM_WID]),
    .flags (rx_flags.src)
  );

  // Transmit checker, driven by the transmit settings.
  afm_phase_check u_tx_chk (
    .clk (clk),
    .reset_n (reset_n),
    .sclk_rise (sclk_rise),
    .ws_rise (ws_rise),
    .ws_fall (ws_fall),
    .balanced (s_ff.ctrl[`AFM_BAL_TX]),
    .period (s_ff.tx_cfg[`AFM_PER]),
    .width (s_ff.tx_cfg[`AFM_WID]),
    .flags (tx_flags.src)
  );

  // ****************************************
  // Overload detection.
  // ****************************************
  // The core must see at most eight bit-clock periods per period.
  assign core_slow = sclk_rise && !rx_core_tick
    && (s_ff.ratio_cnt >= `AFM_RATIO);
  // More requests than the engine can take in one go.
  assign rx_over = $countones(rx_buf_req) > RX_SERVE;
  assign tx_over = $countones(tx_buf_req) > TX_SERVE;

  // ****************************************
  // Status bytes.
  // ****************************************
  // Reserved bits stay zero; nothing written reaches these bytes.
  always_comb begin
    rx_stat = '0;
    rx_stat.ovld = s_ff.rx_ovld;
    rx_stat.err = rx_flags.late | rx_flags.early;
    rx_stat.late = rx_flags.late;
    rx_stat.early = rx_flags.early;
    rx_stat.missing = rx_flags.missing;
    tx_stat = '0;
    tx_stat.starve = s_ff.tx_starve;
    tx_stat.late = tx_flags.late;
    tx_stat.early = tx_flags.early;
    tx_stat.missing = tx_flags.missing;
    cur_flags = {tx_stat[3:0], 3'h0, rx_stat[4:0]};
  end

  // ****************************************
  // Bus handshakes.
  // ****************************************
  // Address and data are taken together once both are offered.
  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_ff.bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  // One read at a time; a new one waits for the last answer.
  assign rd_go = s_axi_arvalid & ~s_ff.rvalid;
  assign s_axi_arready = ~s_ff.rvalid;
  assign waddr = {s_axi_awaddr[`AFM_AW-1:2], 2'h0};
  assign raddr = {s_axi_araddr[`AFM_AW-1:2], 2'h0};

  // Strobe lanes widened to a bit mask.
  genvar g;
  for (g = 0; g < 4; g++) begin : g_lane
    assign wmask[8*g +: 8] = {8{s_axi_wstrb[g]}};
  end

  // ****************************************
  // Next state.
  // ****************************************
  always_comb begin
    nxt_s = s_ff;
    // Link history for edge finding.
    nxt_s.sclk_d = link_q[0];
    nxt_s.ws_d = link_q[1];
    // Bit-clock rises since the last core tick, saturating.
    if (rx_core_tick) begin
      nxt_s.ratio_cnt = {4'h0, sclk_rise};
    end else if (sclk_rise && !(&s_ff.ratio_cnt)) begin
      nxt_s.ratio_cnt = s_ff.ratio_cnt + 1'b1;
    end
    // Overload is a live level of this cycle's causes.
    nxt_s.rx_ovld = rx_over | core_slow
      | rx_flags.short_frm;
    // Starvation mirrors overload on the transmit side.
    nxt_s.tx_starve = tx_over | tx_flags.short_frm;
    // Only rising flags mark an event.
    rises = cur_flags & ~s_ff.flags_d;
    nxt_s.flags_d = cur_flags;
    // Software clears pending bits by writing ones.
    clr = '0;
    if (wr_go && waddr == `AFM_PEND) begin
      clr = s_axi_wdata[11:0] & wmask[11:0];
    end
    // A rise in the clearing cycle wins over the clear.
    nxt_s.pend = ((s_ff.pend & ~clr) | rises) & `AFM_PEND_VALID;
    // Write answer stands until the master takes it.
    if (s_ff.bvalid && s_axi_bready) begin
      nxt_s.bvalid = 1'b0;
    end
    if (wr_go) begin
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = `AFM_OKAY;
      unique case (waddr)
        `AFM_RX_CFG: begin
          nxt_s.rx_cfg = afm_merge(s_ff.rx_cfg, s_axi_wdata, wmask);
        end
        `AFM_TX_CFG: begin
          nxt_s.tx_cfg = afm_merge(s_ff.tx_cfg, s_axi_wdata, wmask);
        end
        `AFM_CTRL: begin
          nxt_s.ctrl = s_axi_wstrb[0] ? s_axi_wdata[1:0] : s_ff.ctrl;
        end
        `AFM_MASK: begin
          nxt_s.mask = 12'(afm_merge({20'h0_0000, s_ff.mask},
            s_axi_wdata, wmask)) & `AFM_PEND_VALID;
        end
        // Pending is handled above; status bytes ignore writes.
        `AFM_PEND, RX_STAT_A, TX_STAT_A: begin
          nxt_s.bresp = `AFM_OKAY;
        end
        // Nothing lives here.
        default: begin
          nxt_s.bresp = `AFM_SLVERR;
        end
      endcase
    end
    // Read answer stands until the master takes it.
    if (s_ff.rvalid && s_axi_rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (rd_go) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp = `AFM_OKAY;
      nxt_s.rdata = '0;
      unique case (raddr)
        `AFM_RX_CFG: begin
          nxt_s.rdata = s_ff.rx_cfg;
        end
        `AFM_TX_CFG: begin
          nxt_s.rdata = s_ff.tx_cfg;
        end
        `AFM_CTRL: begin
          nxt_s.rdata = 32'(s_ff.ctrl);
        end
        `AFM_PEND: begin
          nxt_s.rdata = 32'(s_ff.pend);
        end
        `AFM_MASK: begin
          nxt_s.rdata = 32'(s_ff.mask);
        end
        RX_STAT_A: begin
          nxt_s.rdata = 32'(rx_stat);
        end
        TX_STAT_A: begin
          nxt_s.rdata = 32'(tx_stat);
        end
        // Unmapped reads return zero with an error.
        default: begin
          nxt_s.rresp = `AFM_SLVERR;
        end
      endcase
    end
  end

  // ****************************************
  // State register.
  // ****************************************
  // Settings reset to a plain 64-period, 32-wide frame.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_ff <= '0;
      s_ff.rx_cfg <= `AFM_CFG_RST;
      s_ff.tx_cfg <= `AFM_CFG_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ****************************************
  // Outputs.
  // ****************************************
  assign s_axi_bresp = s_ff.bresp;
  assign s_axi_bvalid = s_ff.bvalid;
  assign s_axi_rdata = s_ff.rdata;
  assign s_axi_rresp = s_ff.rresp;
  assign s_axi_rvalid = s_ff.rvalid;
  // Pending events reach the pin only where the mask allows.
  assign irq = |(s_ff.pend & s_ff.mask);

  // ****************************************
  // Checks.
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  property p_err_or;
    (rx_flags.late || rx_flags.early) |-> rx_stat.err;
  endproperty
  a_err_or: assert property (p_err_or)
    else $error("Receive error bit misses late or early.");

  property p_req_ovld;
    rx_over |=> rx_stat.ovld;
  endproperty
  a_req_ovld: assert property (p_req_ovld)
    else $error("Request overload was not flagged.");

  property p_core_slow;
    core_slow |=> rx_stat.ovld;
  endproperty
  a_core_slow: assert property (p_core_slow)
    else $error("Slow core clock was not flagged.");

  property p_starve;
    tx_over |=> tx_stat.starve;
  endproperty
  a_starve: assert property (p_starve)
    else $error("Transmit starvation was not flagged.");

  sequence s_ovld_rise;
    !s_ff.rx_ovld ##1 s_ff.rx_ovld;
  endsequence
  property p_irq;
    s_ovld_rise ##0 (s_ff.mask[`AFM_PEND_OVLD] && !wr_go)
      |=> s_ff.pend[`AFM_PEND_OVLD] && irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("Unmasked overload rise gave no interrupt.");

  property p_pend_set;
    |rises |=> ((s_ff.pend & $past(rises)) == $past(rises));
  endproperty
  a_pend_set: assert property (p_pend_set)
    else $error("A rising flag did not set its pending bit.");

  property p_rsv;
    (rd_go && raddr == RX_STAT_A) |=> s_axi_rvalid
      && (s_axi_rdata <= 32'h0000_001F);
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("Reserved status bits read nonzero.");
endmodule : afm_top

// [verilog/afm_params.svh]
// What this block does
// - Too many buffer requests flag receive overload.
// - Core clock under bit clock/8 flags overload.
// - Frame or subframe under 16 bits flags receive overload and transmit starvation.
// - Receive error bit is late OR early.
// - Receive phase too long sets late.
// - Receive phase too short sets early.
// - No receive edge for twice period flags missing.
// - Transmit fetch starvation sets starved flag.
// - Transmit phase too long sets late.
// - Transmit phase too short sets early.
// - No transmit edge for twice period flags missing.
// - Flag rise interrupts only when mask allows.
`ifndef AFM_PARAMS_SVH
`define AFM_PARAMS_SVH
// Widths of counters and of the register address.
`define AFM_CNT_W 16
`define AFM_AW 16
// Status registers by index; byte address is four times it.
`define AFM_RX_STAT_IDX 16'h1304
`define AFM_TX_STAT_IDX 16'h1305
// Setting, mode and interrupt registers by byte address.
`define AFM_RX_CFG 16'h0000
`define AFM_TX_CFG 16'h0004
`define AFM_CTRL 16'h0008
`define AFM_PEND 16'h000C
`define AFM_MASK 16'h0010
// Setting fields, reset value and mode bits.
`define AFM_PER 15:0
`define AFM_WID 31:16
`define AFM_CFG_RST 32'h0020_0040
`define AFM_BAL_RX 0
`define AFM_BAL_TX 1
// Pending layout: receive in 4:0, transmit in 11:8.
`define AFM_PEND_VALID 12'hF1F
`define AFM_PEND_OVLD 4
// Ratio limit, shortest frame and bus answers.
`define AFM_RATIO 5'h08
`define AFM_MIN_FRAME 16'h0010
`define AFM_OKAY 2'h0
`define AFM_SLVERR 2'h2
`endif

// [verilog/afm_pkg.sv]
`include "afm_params.svh"

// ****************************************
// Types shared by the monitor modules.
// ****************************************
package afm_pkg;
  // A bit-clock period count.
  typedef logic [`AFM_CNT_W-1:0] afm_cnt_t;

  // Receive status byte, reserved bits on top.
  typedef struct packed {
    logic [2:0] rsv;
    logic ovld;
    logic err;
    logic late;
    logic early;
    logic missing;
  } afm_rx_stat_t;

  // Transmit status byte, reserved bits on top.
  typedef struct packed {
    logic [3:0] rsv;
    logic starve;
    logic late;
    logic early;
    logic missing;
  } afm_tx_stat_t;

  // Two-stage synchroniser for bit clock and word select.
  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] stable;
  } afm_sync_t;

  // State of one phase checker.
  typedef struct packed {
    afm_cnt_t phase_cnt;
    afm_cnt_t frame_cnt;
    logic [`AFM_CNT_W:0] idle_cnt;
    logic started;
    logic framed;
    logic late;
    logic early;
    logic missing;
    logic short_frm;
  } afm_chk_t;

  // State of the top level: link edges, flags, registers, bus.
  typedef struct packed {
    logic sclk_d;
    logic ws_d;
    logic [4:0] ratio_cnt;
    logic rx_ovld;
    logic tx_starve;
    logic [11:0] flags_d;
    logic [31:0] rx_cfg;
    logic [31:0] tx_cfg;
    logic [1:0] ctrl;
    logic [11:0] pend;
    logic [11:0] mask;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } afm_top_t;
endpackage : afm_pkg

// [verilog/afm_flag_if.sv]
// ****************************************
// Results of one phase checker.
// ****************************************
interface afm_flag_if;
  logic late;
  logic early;
  logic missing;
  logic short_frm;
  modport src (output late, early, missing, short_frm);
  modport dst (input late, early, missing, short_frm);
endinterface : afm_flag_if

// [verilog/afm_sync.sv]
`include "afm_params.svh"

// ****************************************
// Two-flop synchroniser for the link pins.
// ****************************************
module afm_sync
  import afm_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Pins in, bit 0 bit clock, bit 1 word select.
  input wire logic [1:0] pin_in,
  // Synchronised copies.
  output logic [1:0] pin_sync
);
  afm_sync_t s_ff; // Both stages.
  afm_sync_t nxt_s; // Next value of both stages.

  // The first stage feeds only the second stage.
  always_comb begin
    nxt_s.meta = pin_in;
    nxt_s.stable = s_ff.meta;
  end

  // Registers the stages.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign pin_sync = s_ff.stable;
endmodule : afm_sync

// [verilog/afm_phase_check.sv]
`include "afm_params.svh"

// ****************************************
// Phase length checker for one direction.
// ****************************************
module afm_phase_check
  import afm_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Link edges, one-cycle pulses.
  input wire logic sclk_rise,
  input wire logic ws_rise,
  input wire logic ws_fall,
  // Settings.
  input wire logic balanced,
  input wire afm_cnt_t period,
  input wire afm_cnt_t width,
  // Results.
  afm_flag_if.src flags
);
  afm_chk_t s_ff; // Checker state.
  afm_chk_t nxt_s; // Next checker state.
  afm_cnt_t exp_high; // Expected high phase.
  afm_cnt_t ended_exp; // Expected length of the phase now ending.
  logic ws_edge; // Any word select edge.
  logic [`AFM_CNT_W:0] twice; // Twice the frame period.

  // Counts bit-clock rises and judges each phase at its end.
  // The first phase after reset is partial, so it is not judged.
  always_comb begin
    ws_edge = ws_rise | ws_fall;
    exp_high = balanced ? (period >> 1) : width;
    ended_exp = ws_rise ? (period - exp_high) : exp_high;
    twice = {period, 1'b0};
    nxt_s = s_ff;
    nxt_s.short_frm = 1'b0;
    if (sclk_rise && !(&s_ff.phase_cnt)) begin
      nxt_s.phase_cnt = s_ff.phase_cnt + 1'b1;
    end
    if (sclk_rise && !(&s_ff.frame_cnt)) begin
      nxt_s.frame_cnt = s_ff.frame_cnt + 1'b1;
    end
    if (sclk_rise && !(&s_ff.idle_cnt)) begin
      nxt_s.idle_cnt = s_ff.idle_cnt + 1'b1;
    end
    nxt_s.missing = !ws_edge && (s_ff.idle_cnt > twice);
    if (ws_edge) begin
      nxt_s.started = 1'b1;
      nxt_s.phase_cnt = afm_cnt_t'(sclk_rise);
      nxt_s.idle_cnt = (`AFM_CNT_W+1)'(sclk_rise);
      if (s_ff.started) begin
        nxt_s.late = s_ff.phase_cnt > ended_exp;
        nxt_s.early = s_ff.phase_cnt < ended_exp;
        if (balanced) begin
          nxt_s.short_frm = s_ff.phase_cnt < `AFM_MIN_FRAME;
        end
      end
    end
    if (ws_rise) begin
      nxt_s.framed = 1'b1;
      nxt_s.frame_cnt = afm_cnt_t'(sclk_rise);
      if (s_ff.framed && !balanced) begin
        nxt_s.short_frm = s_ff.frame_cnt < `AFM_MIN_FRAME;
      end
    end
  end

  // Registers the checker state.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign flags.late = s_ff.late;
  assign flags.early = s_ff.early;
  assign flags.missing = s_ff.missing;
  assign flags.short_frm = s_ff.short_frm;

  // ****************************************
  // Checks.
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  property p_late;
    ws_edge && s_ff.started && (s_ff.phase_cnt > ended_exp)
      |=> flags.late && !flags.early;
  endproperty
  a_late: assert property (p_late)
    else $error("Long phase did not raise late.");

  property p_early;
    ws_edge && s_ff.started && (s_ff.phase_cnt < ended_exp)
      |=> flags.early && !flags.late;
  endproperty
  a_early: assert property (p_early)
    else $error("Short phase did not raise early.");

  sequence s_silent;
    !ws_edge && (s_ff.idle_cnt > twice);
  endsequence
  property p_missing;
    s_silent |=> flags.missing;
  endproperty
  a_missing: assert property (p_missing)
    else $error("Silent link did not raise missing.");

  property p_short;
    ws_edge && s_ff.started && balanced
      && (s_ff.phase_cnt < `AFM_MIN_FRAME) |=> flags.short_frm;
  endproperty
  a_short: assert property (p_short)
    else $error("Short subframe was not flagged.");
endmodule : afm_phase_check

// [testbench/afm_host_model.sv]
// ****************************************
// Host audio controller driving the link.
// ****************************************
module afm_host_model (
  // Link pins towards the monitor.
  output logic sclk,
  output logic word_select
);
  timeunit 1ns;
  timeprecision 100ps;
  // The bit clock rests low between phases, as a real host may stop it.
  initial begin
    sclk = 1'b0;
    word_select = 1'b0;
  end
  // Set word select, then give n bit clocks of 125 ns.
  task automatic phase(input logic lvl, input int n);
    word_select = lvl;
    repeat (n) begin
      #62.5 sclk = 1'b1;
      #62.5 sclk = 1'b0;
    end
  endtask : phase
endmodule : afm_host_model

// [testbench/tb_top.sv]
`include "afm_params.svh"

// ****************************************
// Self-checking bench for the monitor.
// ****************************************
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // Clock, reset and bus wires.
  logic clk, reset_n, aw_valid, aw_ready, w_valid, w_ready, b_valid;
  logic b_ready, ar_valid, ar_ready, r_valid, r_ready, irq, tick;
  logic [15:0] aw_addr, ar_addr;
  logic [31:0] w_data, r_data;
  logic [1:0] b_resp, r_resp;
  logic [3:0] rx_req, tx_req;
  wire sclk, word_select;
  int n_errors = 0;
  int n_compared = 0;
  // Status addresses are four times their index.
  localparam logic [15:0] rx_st = 16'(`AFM_RX_STAT_IDX * 4);
  localparam logic [15:0] tx_st = 16'(`AFM_TX_STAT_IDX * 4);
  afm_host_model host (.sclk(sclk), .word_select(word_select));
  afm_top dut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(aw_addr),
    .s_axi_awvalid(aw_valid), .s_axi_awready(aw_ready),
    .s_axi_wdata(w_data), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_valid),
    .s_axi_wready(w_ready), .s_axi_bresp(b_resp), .s_axi_bvalid(b_valid),
    .s_axi_bready(b_ready), .s_axi_araddr(ar_addr),
    .s_axi_arvalid(ar_valid), .s_axi_arready(ar_ready),
    .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_valid),
    .s_axi_rready(r_ready), .sclk(sclk), .word_select(word_select),
    .rx_core_tick(tick), .rx_buf_req(rx_req), .tx_buf_req(tx_req),
    .irq(irq));
  // Free-running 250 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Count one comparison and report a mismatch.
  task automatic chk(input string what, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // Wait a number of clock edges, letting the last one settle.
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  // One write; address and data are held until both are taken.
  task automatic wr(input logic [15:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic [1:0] got;
    @(posedge clk);
    aw_addr <= a;
    w_data <= d;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    #1;
    while (!(aw_ready && w_ready)) wt(1);
    @(posedge clk);
    aw_valid <= 1'b0;
    w_valid <= 1'b0;
    #1;
    while (b_valid !== 1'b1) wt(1);
    got = b_resp;
    @(posedge clk);
    b_ready <= 1'b0;
    #1;
    chk("bresp", {30'h0, er}, {30'h0, got});
  endtask : wr
  // One read; the data is masked and compared with the expectation.
  task automatic rd(input string what, input logic [15:0] a,
                    input logic [31:0] m, e, input logic [1:0] er);
    logic [31:0] got;
    logic [1:0] resp;
    @(posedge clk);
    ar_addr <= a;
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    #1;
    while (!ar_ready) wt(1);
    @(posedge clk);
    ar_valid <= 1'b0;
    #1;
    while (r_valid !== 1'b1) wt(1);
    got = r_data;
    resp = r_resp;
    @(posedge clk);
    r_ready <= 1'b0;
    #1;
    chk(what, e, got & m);
    chk("rresp", {30'h0, er}, {30'h0, resp});
  endtask : rd
  // Read both status registers after the link edges have settled.
  task automatic st(input logic [7:0] erx, etx);
    wt(10);
    rd("rx status", rx_st, '1, {24'h0, erx}, `AFM_OKAY);
    rd("tx status", tx_st, '1, {24'h0, etx}, `AFM_OKAY);
  endtask : st
  // Reset values, read-only status, unmapped place, then setup.
  task automatic t_regs;
    rd("rx cfg", `AFM_RX_CFG, '1, `AFM_CFG_RST, `AFM_OKAY);
    st(8'h00, 8'h00);
    wr(rx_st, 32'h0000_00FF, `AFM_OKAY);
    st(8'h00, 8'h00);
    rd("unmapped", 16'h0100, '1, 32'h0, `AFM_SLVERR);
    wr(`AFM_RX_CFG, 32'h0008_0018, `AFM_OKAY);
    wr(`AFM_TX_CFG, 32'h0008_0018, `AFM_OKAY);
    $display("test regs done");
  endtask : t_regs
  // Good frames, then long, short and missing word-select phases.
  task automatic t_phase;
    repeat (3) begin
      host.phase(1'b0, 16);
      host.phase(1'b1, 8);
    end
    host.phase(1'b0, 0);
    st(8'h00, 8'h00);
    host.phase(1'b0, 16);
    host.phase(1'b1, 9);
    host.phase(1'b0, 0);
    st(8'h0C, 8'h04);
    host.phase(1'b0, 16);
    host.phase(1'b1, 7);
    host.phase(1'b0, 0);
    st(8'h0A, 8'h02);
    host.phase(1'b0, 17);
    host.phase(1'b1, 8);
    st(8'h0C, 8'h04);
    host.phase(1'b0, 48);
    st(8'h00, 8'h00);
    host.phase(1'b0, 1);
    st(8'h01, 8'h01);
    host.phase(1'b1, 0);
    st(8'h0C, 8'h04);
    $display("test phase done");
  endtask : t_phase
  // Overload and starvation events through pending, mask and irq.
  task automatic t_irq;
    wr(`AFM_PEND, 32'h0000_0FFF, `AFM_OKAY);
    wr(`AFM_MASK, 32'h0000_0010, `AFM_OKAY);
    chk("irq idle", 32'h0, {31'h0, irq});
    @(posedge clk);
    rx_req <= 4'b0011;
    tx_req <= 4'b0011;
    @(posedge clk);
    rx_req <= 4'b0000;
    tx_req <= 4'b0000;
    wt(4);
    chk("irq set", 32'h1, {31'h0, irq});
    rd("pend", `AFM_PEND, '1, 32'h0000_0810, `AFM_OKAY);
    wr(`AFM_PEND, 32'h0000_0010, `AFM_OKAY);
    wt(2);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`AFM_PEND, 32'h0000_0800, `AFM_OKAY);
    tick <= 1'b0;
    host.phase(1'b1, 8);
    rd("pend ratio", `AFM_PEND, '1, 32'h0, `AFM_OKAY);
    host.phase(1'b1, 1);
    wt(10);
    rd("pend ratio", `AFM_PEND, '1, 32'h0000_0010, `AFM_OKAY);
    chk("irq ratio", 32'h1, {31'h0, irq});
    tick <= 1'b1;
    wr(`AFM_PEND, 32'h0000_0FFF, `AFM_OKAY);
    host.phase(1'b0, 8);
    host.phase(1'b1, 7);
    host.phase(1'b0, 8);
    host.phase(1'b1, 0);
    wt(10);
    rd("pend short", `AFM_PEND, 32'h810, 32'h810, `AFM_OKAY);
    // Balanced halves of 12 are on time but each subframe is too short.
    wr(`AFM_CTRL, 32'h0000_0003, `AFM_OKAY);
    wr(`AFM_PEND, 32'h0000_0FFF, `AFM_OKAY);
    host.phase(1'b0, 12);
    host.phase(1'b1, 12);
    host.phase(1'b0, 0);
    st(8'h00, 8'h00);
    rd("pend half", `AFM_PEND, 32'h810, 32'h810, `AFM_OKAY);
    $display("test irq done");
  endtask : t_irq
  // Print the counts and the verdict, then end the run.
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  // Main sequence; transmit requests stay quiet outside t_irq.
  initial begin
    {aw_valid, w_valid, b_ready, ar_valid, r_ready} = '0;
    {aw_addr, ar_addr, w_data, rx_req, tx_req} = '0;
    tick = 1'b1;
    reset_n = 1'b0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_phase();
    t_irq();
    stop_test();
  end
  // The tests need about 32 us; a hang is cut off well beyond that.
  initial begin
    #200000;
    n_errors++;
    stop_test();
  end
endmodule : tb_top
